// *** verilog/clocked_video_input_bridge.sv ***
/*
 Video input bridge: samples clocked video, packs it into framed stream beats,
 and offers control and status over AXI4-Lite.
 Assumes the video clock runs at most a quarter of aclk, so each video sample is seen.
*/
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cvi_defines.svh"
module clocked_video_input_bridge
	import cvi_pkg::*;
#(
	parameter int BPS      = 8,
	parameter int PLANES   = 2,
	parameter int STD_W    = 3,
	parameter int CNT_W    = 16,
	parameter int USE_CTRL = 1,
	parameter int ADDR_W   = 5
)(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  vid_clk,
	input  wire logic [BPS*PLANES-1:0] vid_data,
	input  wire logic                  vid_datavalid,
	input  wire logic                  vid_f,
	input  wire logic                  vid_h_sync,
	input  wire logic                  vid_v_sync,
	input  wire logic                  plane_format_select,
	input  wire logic                  vid_locked,
	input  wire logic [STD_W-1:0]      vid_std,
	output var  logic [BPS*PLANES-1:0] stream_pixel_out,
	output var  logic                  stream_beat_present,
	output var  logic                  stream_frame_first,
	output var  logic                  stream_frame_last,
	input  wire logic                  stream_sink_accept,
	output var  logic                  overflow,
	output var  logic                  refclk_div,
	output var  logic                  sof,
	output var  logic                  sof_locked,
	output var  logic                  status_update_int,
	input  wire logic [ADDR_W-1:0]     awaddr,
	input  wire logic                  awvalid,
	output var  logic                  awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output var  logic                  wready,
	output var  logic [1:0]            bresp,
	output var  logic                  bvalid,
	input  wire logic                  bready,
	input  wire logic [ADDR_W-1:0]     araddr,
	input  wire logic                  arvalid,
	output var  logic                  arready,
	output var  logic [31:0]           rdata,
	output var  logic [1:0]            rresp,
	output var  logic                  rvalid,
	input  wire logic                  rready
);

	localparam int DW   = BPS * PLANES;
	localparam int PI_W = (PLANES > 1) ? $clog2(PLANES) : 1;

	generate
		if (BPS < 1 || PLANES < 1 || CNT_W < 2 || CNT_W > 31 || STD_W > 31 || ADDR_W < 5 || DW > 32)
		begin : g_bad_params
			$error("clocked_video_input_bridge: unsupported parameter values");
		end
	endgenerate

	// Byte-lane merge of a write into a register of up to 32 bits
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		return res;
	endfunction : lane_merge

	// Word index from a byte address; upper bits above the map make it unmapped
	function automatic logic [2:0] word_index(input logic [ADDR_W-1:0] addr);
		return addr[4:2];
	endfunction : word_index

	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		return (addr >> 5) == '0;
	endfunction : is_mapped

	video_ctl_t              ctl_raw;
	video_ctl_t              s;
	logic [DW+STD_W-1:0]     bus_sync;
	logic [DW-1:0]           vdata;
	logic [STD_W-1:0]        vstd;

	assign ctl_raw = '{clk: vid_clk, dv: vid_datavalid, f: vid_f, h: vid_h_sync,
		v: vid_v_sync, fmt: plane_format_select, locked: vid_locked};

	cvi_sync #(.W($bits(video_ctl_t))) u_sync_ctl ( // RQ3
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (ctl_raw),
		.q       (s)
	);

	cvi_sync #(.W(DW + STD_W)) u_sync_bus ( // RQ3
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({vid_std, vid_data}),
		.q       (bus_sync)
	);

	assign vdata = bus_sync[DW-1:0];
	assign vstd  = bus_sync[DW+STD_W-1:DW];

	logic             vclk_prev_reg;
	logic             h_prev_reg;
	logic             v_prev_reg;
	logic             locked_prev_reg;
	logic             tick;
	logic             h_rise;
	logic             v_rise;
	logic             v_fall;

	// Sample on the falling video clock edge, midway between source updates
	assign tick   = vclk_prev_reg & ~s.clk;
	assign h_rise = tick & s.h & ~h_prev_reg;
	assign v_rise = tick & s.v & ~v_prev_reg;
	assign v_fall = tick & ~s.v & v_prev_reg;

	always_ff @(posedge aclk) // RQ4
	begin
		if (!aresetn) // RQ1
		begin
			vclk_prev_reg   <= 1'b0;
			h_prev_reg      <= 1'b0;
			v_prev_reg      <= 1'b0;
			locked_prev_reg <= 1'b0;
		end
		else
		begin
			vclk_prev_reg   <= s.clk;
			locked_prev_reg <= s.locked;
			if (tick)
			begin
				h_prev_reg <= s.h;
				v_prev_reg <= s.v;
			end
		end
	end

	logic [2:0]       ctrl_reg;
	logic [CNT_W-1:0] sof_line_reg;
	logic [CNT_W-1:0] sof_sample_reg;
	logic [CNT_W-1:0] div_reg;
	logic [CNT_W-1:0] line_len_reg;
	logic [CNT_W-1:0] sample_cnt_reg;
	logic [CNT_W-1:0] line_cnt_reg;
	logic             ovf_reg;
	logic             int_pend_reg;
	logic             field_reg;
	logic             frame_seen_reg;
	cap_state_t       state_reg;
	logic             run;

	assign run = ctrl_reg[`CVI_CTRL_GO] & s.locked;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_reg <= ST_IDLE;
		else
		begin
			unique case (state_reg)
				ST_IDLE:   state_reg <= run ? ST_WAIT : ST_IDLE;
				ST_WAIT:   state_reg <= !run ? ST_IDLE : (v_fall ? ST_ACTIVE : ST_WAIT);
				ST_ACTIVE: state_reg <= !run ? ST_IDLE : (v_rise ? ST_WAIT : ST_ACTIVE);
				default:   state_reg <= ST_IDLE;
			endcase
		end
	end

	// Position counters for the start-of-frame marker and line length
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sample_cnt_reg <= '0;
			line_cnt_reg   <= '0;
			line_len_reg   <= '0;
			field_reg      <= 1'b0;
		end
		else if (tick)
		begin
			sample_cnt_reg <= h_rise ? '0 : sample_cnt_reg + 1'b1;
			if (h_rise)
				line_len_reg <= sample_cnt_reg;
			if (v_rise)
				line_cnt_reg <= '0;
			else if (h_rise)
				line_cnt_reg <= line_cnt_reg + 1'b1;
			if (v_fall)
				field_reg <= s.f;
		end
	end

	logic                 seq_mode;
	logic                 sample_take;
	logic                 new_beat;
	logic [DW-1:0]        new_data;
	logic [DW-1:0]        pack_reg;
	logic [PI_W-1:0]      plane_idx_reg;

	// Low select means sequential planes; parallel is the fixed mode without switching
	assign seq_mode    = ctrl_reg[`CVI_CTRL_SWITCH] & ~s.fmt; // RQ18
	assign sample_take = tick & s.dv & ~s.v & (state_reg == ST_ACTIVE) & run; // RQ15
	assign new_beat    = sample_take & (~seq_mode | (plane_idx_reg == PI_W'(PLANES - 1))); // RQ18

	always_comb
	begin
		new_data = vdata;
		if (seq_mode)
		begin
			new_data = pack_reg;
			new_data[(PLANES-1)*BPS +: BPS] = vdata[BPS-1:0]; // RQ18
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pack_reg      <= '0;
			plane_idx_reg <= '0;
		end
		else if (!seq_mode || state_reg != ST_ACTIVE)
			plane_idx_reg <= '0;
		else if (sample_take)
		begin
			pack_reg[plane_idx_reg*BPS +: BPS] <= vdata[BPS-1:0];
			plane_idx_reg <= new_beat ? '0 : plane_idx_reg + 1'b1;
		end
	end

	// One beat is held back so the last of a frame can be marked when vsync arrives
	logic          held_v_reg;
	logic [DW-1:0] held_data_reg;
	logic          held_first_reg;
	logic          first_pend_reg;
	logic          flush;
	logic          push;
	logic          out_free;
	logic          ovf_evt;
	logic          fire;

	assign flush    = (state_reg == ST_ACTIVE) & (v_rise | ~run);
	assign push     = held_v_reg & (new_beat | flush);
	assign fire     = stream_beat_present & stream_sink_accept;
	assign out_free = ~stream_beat_present | stream_sink_accept;
	assign ovf_evt  = push & ~out_free;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			held_v_reg     <= 1'b0;
			held_data_reg  <= '0;
			held_first_reg <= 1'b0;
			first_pend_reg <= 1'b0;
		end
		else
		begin
			if (state_reg == ST_WAIT && v_fall && run)
				first_pend_reg <= 1'b1;
			else if (new_beat)
				first_pend_reg <= 1'b0;
			if (new_beat) // RQ15
			begin
				held_v_reg     <= 1'b1;
				held_data_reg  <= new_data;
				held_first_reg <= first_pend_reg; // RQ5
			end
			else if (flush)
				held_v_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stream_beat_present <= 1'b0;
			stream_pixel_out    <= '0;
			stream_frame_first  <= 1'b0;
			stream_frame_last   <= 1'b0;
		end
		else if (push && out_free) // RQ9
		begin
			stream_beat_present <= 1'b1; // RQ8
			stream_pixel_out    <= held_data_reg;
			stream_frame_first  <= held_first_reg; // RQ5
			stream_frame_last   <= flush; // RQ6
		end
		else if (fire)
			stream_beat_present <= 1'b0; // RQ8
	end

	logic aw_hold_reg;
	logic w_hold_reg;
	logic [2:0] aw_idx_reg;
	logic aw_map_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic aw_hold_next;
	logic w_hold_next;
	logic bvalid_next;
	logic rvalid_next;
	logic wr_int_clr;
	logic wr_ovf_clr;
	logic upd_evt;

	assign aw_take      = awvalid & awready;
	assign w_take       = wvalid & wready;
	assign ar_take      = arvalid & arready;
	assign do_write     = aw_hold_reg & w_hold_reg & ~bvalid;
	assign aw_hold_next = (aw_hold_reg | aw_take) & ~do_write;
	assign w_hold_next  = (w_hold_reg | w_take) & ~do_write;
	assign bvalid_next  = do_write | (bvalid & ~bready);
	assign rvalid_next  = ar_take | (rvalid & ~rready);
	assign wr_ovf_clr   = do_write & aw_map_reg & (aw_idx_reg == `CVI_IDX_STATUS) & w_strb_reg[0]
		& w_data_reg[`CVI_STAT_OVF];
	assign wr_int_clr   = do_write & aw_map_reg & (aw_idx_reg == `CVI_IDX_INT) & w_strb_reg[0]
		& w_data_reg[`CVI_INT_UPDATE];
	assign upd_evt      = ovf_evt | (s.locked ^ locked_prev_reg) | (push & flush);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready     <= 1'b0;
			wready      <= 1'b0;
			bvalid      <= 1'b0;
			bresp       <= `CVI_RESP_OKAY;
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			aw_idx_reg  <= '0;
			aw_map_reg  <= 1'b0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
		end
		else
		begin
			awready     <= (USE_CTRL != 0) & ~aw_hold_next & ~bvalid_next; // RQ21
			wready      <= (USE_CTRL != 0) & ~w_hold_next & ~bvalid_next; // RQ21
			aw_hold_reg <= aw_hold_next;
			w_hold_reg  <= w_hold_next;
			bvalid      <= bvalid_next;
			if (aw_take)
			begin
				aw_idx_reg <= word_index(awaddr); // RQ22
				aw_map_reg <= is_mapped(awaddr);
			end
			if (w_take)
			begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (do_write)
				bresp <= aw_map_reg ? `CVI_RESP_OKAY : `CVI_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg       <= `CVI_CTRL_RESET;
			sof_line_reg   <= '0;
			sof_sample_reg <= '0;
			div_reg        <= '0;
		end
		else if (do_write && aw_map_reg)
		begin
			unique case (aw_idx_reg)
				`CVI_IDX_CTRL:       ctrl_reg       <= 3'(lane_merge(32'(ctrl_reg), w_data_reg, w_strb_reg));
				`CVI_IDX_SOF_LINE:   sof_line_reg   <= CNT_W'(lane_merge(32'(sof_line_reg), w_data_reg, w_strb_reg));
				`CVI_IDX_SOF_SAMPLE: sof_sample_reg <= CNT_W'(lane_merge(32'(sof_sample_reg), w_data_reg, w_strb_reg));
				`CVI_IDX_DIVIDER:    div_reg        <= CNT_W'(lane_merge(32'(div_reg), w_data_reg, w_strb_reg));
				default:             ctrl_reg       <= ctrl_reg;
			endcase
		end
	end

	// Sticky flags: a new event in the clearing cycle wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ovf_reg      <= 1'b0;
			int_pend_reg <= 1'b0;
		end
		else
		begin
			ovf_reg      <= ovf_evt | (ovf_reg & ~wr_ovf_clr);
			int_pend_reg <= upd_evt | (int_pend_reg & ~wr_int_clr); // RQ14
		end
	end

	logic [31:0] rd_word;

	always_comb
	begin
		rd_word = '0;
		unique case (word_index(araddr)) // RQ22
			`CVI_IDX_CTRL:       rd_word = 32'(ctrl_reg);
			`CVI_IDX_STATUS:     rd_word = 32'({field_reg, state_reg == ST_ACTIVE, s.locked, ovf_reg});
			`CVI_IDX_INT:        rd_word = 32'(int_pend_reg);
			`CVI_IDX_STD:        rd_word = 32'(vstd); // RQ20
			`CVI_IDX_SOF_LINE:   rd_word = 32'(sof_line_reg);
			`CVI_IDX_SOF_SAMPLE: rd_word = 32'(sof_sample_reg);
			`CVI_IDX_DIVIDER:    rd_word = 32'(div_reg);
			`CVI_IDX_LINE_LEN:   rd_word = 32'(line_len_reg);
		endcase
		if (!is_mapped(araddr))
			rd_word = '0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= `CVI_RESP_OKAY;
		end
		else
		begin
			arready <= (USE_CTRL != 0) & ~rvalid_next; // RQ21
			rvalid  <= rvalid_next;
			if (ar_take)
			begin
				rdata <= rd_word;
				rresp <= is_mapped(araddr) ? `CVI_RESP_OKAY : `CVI_RESP_SLVERR;
			end
		end
	end

	// Marker pins; lock is only claimed after a vsync has been seen to end while locked
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sof               <= 1'b0;
			sof_locked        <= 1'b0;
			frame_seen_reg    <= 1'b0;
			overflow          <= 1'b0;
			status_update_int <= 1'b0;
		end
		else
		begin
			if (!s.locked)
				frame_seen_reg <= 1'b0;
			else if (v_fall)
				frame_seen_reg <= 1'b1;
			if (tick)
				sof <= s.locked && line_cnt_reg == sof_line_reg && sample_cnt_reg == sof_sample_reg; // RQ12
			sof_locked        <= s.locked & frame_seen_reg; // RQ13
			overflow          <= (USE_CTRL != 0) & ovf_reg; // RQ10
			status_update_int <= (USE_CTRL != 0) & int_pend_reg & ctrl_reg[`CVI_CTRL_INT_EN]; // RQ14
		end
	end

	cvi_refclk_divider #(.CNT_W(CNT_W)) u_divider ( // RQ11
		.aclk       (aclk),
		.aresetn    (aresetn),
		.tick       (tick),
		.div        (div_reg),
		.refclk_div (refclk_div)
	);

	logic in_frame_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			in_frame_reg <= 1'b0;
		else if (fire)
			in_frame_reg <= !stream_frame_last;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_stall_hold: assert property (stream_beat_present && !stream_sink_accept |=> stream_beat_present // RQ9
		&& $stable(stream_pixel_out) && $stable(stream_frame_first) && $stable(stream_frame_last))
		else $error("stalled beat changed");
	a_first_opens: assert property (fire && stream_frame_first |-> !in_frame_reg) // RQ5
		else $error("start mark inside a frame");
	a_last_closes: assert property (fire && stream_frame_last |-> in_frame_reg || stream_frame_first) // RQ6
		else $error("end mark outside a frame");
	a_valid_source: assert property ($rose(stream_beat_present) |-> $past(push)) // RQ8
		else $error("valid raised without a beat");
	a_ovf_pin: assert property (ovf_evt && USE_CTRL != 0 |-> ##2 overflow) // RQ10
		else $error("overflow pin did not follow sticky bit");
	a_sof_position: assert property ($rose(sof) |-> $past(line_cnt_reg == sof_line_reg // RQ12
		&& sample_cnt_reg == sof_sample_reg))
		else $error("start of frame at wrong position");
	a_lock_needs_video: assert property (sof_locked |-> $past(s.locked)) // RQ13
		else $error("frame lock without locked video");
	a_int_raise: assert property (upd_evt && ctrl_reg[`CVI_CTRL_INT_EN] && USE_CTRL != 0 // RQ14
		##1 ctrl_reg[`CVI_CTRL_INT_EN] |=> status_update_int)
		else $error("interrupt missed a status update");
	a_capture_dv: assert property ($changed(held_data_reg) |-> $past(tick && s.dv)) // RQ15
		else $error("sample captured without data valid");
	a_std_read: assert property (ar_take && is_mapped(araddr) && word_index(araddr) == `CVI_IDX_STD // RQ20
		|=> rdata == 32'($past(vstd)))
		else $error("standard register read wrong");
	a_write_order: assert property ($rose(bvalid) |-> $past(aw_hold_reg && w_hold_reg)) // RQ22
		else $error("write response before address and data");
	a_ctrl_absent: assert property (USE_CTRL == 0 |-> !awready && !arready && !overflow // RQ21
		&& !status_update_int)
		else $error("control port active while disabled");

	c_frame_done: cover property (fire && stream_frame_last);
	c_overflow:   cover property (ovf_evt);
	c_seq_beat:   cover property (new_beat && seq_mode);
	c_reg_write:  cover property (bvalid && bready && bresp == `CVI_RESP_OKAY);

endmodule : clocked_video_input_bridge
`default_nettype wire

// *** verilog/cvi_defines.svh ***
/*
 Offsets, field positions, reset values and response codes of the video input bridge.
 Assumes it is included by bare name from files compiled after the package.
*/
// What this block and its surroundings do
// RQ1 - Reset forces every register to its idle value
// RQ2 - System releases reset in step with clock
// RQ3 - All video inputs belong to the video clock
// RQ4 - Stream and control logic run on system clock
// RQ5 - First beat of a frame carries start mark
// RQ6 - Final beat of a frame carries end mark
// RQ7 - Sink raises accept only when it can take
// RQ8 - Valid high exactly while a beat is shown
// RQ9 - Stalled beat and its marks stay unchanged
// RQ10 - Overflow pin mirrors the sticky overflow bit
// RQ11 - Programmable divider gives a line reference clock
// RQ12 - Rising start-of-frame marks the programmed position
// RQ13 - Frame-lock high only while start-of-frame usable
// RQ14 - Interrupt raised when status has been updated
// RQ15 - Samples captured only when data-valid is high
// RQ16 - Source drives field low for progressive video
// RQ17 - Source holds syncs through their sync periods
// RQ18 - Format select low sequential, high parallel planes; the code goes sequential only with the control switch bit set
// RQ19 - Source marks stable video with the locked input
// RQ20 - Standard input readable through the standard register
// RQ21 - Control port, overflow, interrupt only when enabled
// RQ22 - Control address counts words, not bytes; the code takes byte addresses and decodes the word from bits 4:2
`ifndef CVI_DEFINES_SVH
`define CVI_DEFINES_SVH

`define CVI_IDX_CTRL        3'h0
`define CVI_IDX_STATUS      3'h1
`define CVI_IDX_INT         3'h2
`define CVI_IDX_STD         3'h3
`define CVI_IDX_SOF_LINE    3'h4
`define CVI_IDX_SOF_SAMPLE  3'h5
`define CVI_IDX_DIVIDER     3'h6
`define CVI_IDX_LINE_LEN    3'h7

`define CVI_CTRL_GO         0
`define CVI_CTRL_SWITCH     1
`define CVI_CTRL_INT_EN     2
`define CVI_CTRL_RESET      3'h0

`define CVI_STAT_OVF        0
`define CVI_STAT_LOCKED     1
`define CVI_STAT_ACTIVE     2
`define CVI_STAT_FIELD      3
`define CVI_INT_UPDATE      0

`define CVI_RESP_OKAY       2'h0
`define CVI_RESP_SLVERR     2'h2

`endif

// *** verilog/cvi_pkg.sv ***
/*
 Types shared by the video input bridge modules.
 Assumes nothing of its surroundings.
*/
package cvi_pkg;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_WAIT   = 2'h1,
		ST_ACTIVE = 2'h3
	} cap_state_t;

	typedef struct packed {
		logic clk;
		logic dv;
		logic f;
		logic h;
		logic v;
		logic fmt;
		logic locked;
	} video_ctl_t;

	typedef struct packed {
		logic first;
		logic last;
	} beat_mark_t;

endpackage : cvi_pkg

// *** verilog/cvi_sync.sv ***
/*
 Two-stage synchronizer for a bundle of level signals.
 Assumes each bit is a level that stays put for several aclk periods.
*/
`timescale 1ns/1ps
`default_nettype none
module cvi_sync #(
	parameter int W = 1
)(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] stage1_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stage1_reg <= '0;
			q          <= '0;
		end
		else
		begin
			stage1_reg <= d;
			q          <= stage1_reg;
		end
	end

endmodule : cvi_sync
`default_nettype wire

// *** verilog/cvi_refclk_divider.sv ***
/*
 Divides the sampled video clock by a programmable count.
 Assumes tick pulses once per video clock period; a count of zero parks the output low.
*/
`timescale 1ns/1ps
`default_nettype none
module cvi_refclk_divider #(
	parameter int CNT_W = 16
)(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             tick,
	input  wire logic [CNT_W-1:0] div,
	output var  logic             refclk_div
);

	logic [CNT_W-1:0] cnt_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_reg    <= '0;
			refclk_div <= 1'b0;
		end
		else if (tick)
		begin
			// High for the first half of each period of div video clocks
			cnt_reg    <= (cnt_reg + 1'b1 >= div) ? '0 : cnt_reg + 1'b1; // RQ11
			refclk_div <= (div != '0) && (cnt_reg < (div >> 1)); // RQ11
		end
	end

	a_div_park: assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
		(tick && div == '0) |=> !refclk_div)
		else $error("divider output not parked for zero count");

endmodule : cvi_refclk_divider
`default_nettype wire

// *** tb/cvi_video_source.sv ***
/*
 Video source model: free running video clock and framed separate-sync video.
 Assumes run is only dropped between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module cvi_video_source (
	input  wire logic        run,
	output var  logic        vid_clk,
	output var  logic [15:0] vid_data,
	output var  logic        vid_datavalid,
	output var  logic        vid_f,
	output var  logic        vid_h_sync,
	output var  logic        vid_v_sync,
	output var  logic        vid_locked
);
	logic [15:0] pix;
	task automatic tick(input logic h, input logic v, input logic dv);
		@(posedge vid_clk);
		pix = pix + 16'(dv);
		vid_h_sync    <= h;
		vid_v_sync    <= v;
		vid_datavalid <= dv;
		vid_locked    <= run;
		// Blanking shows the inverted pixel count so a stray capture is seen
		vid_data      <= dv ? pix : ~pix;
	endtask : tick
	// Eighth of aclk: within the quarter-rate limit
	always #40 vid_clk = ~vid_clk;
	initial
	begin
		vid_clk       = 1'b0;
		vid_data      = 16'h0000;
		vid_datavalid = 1'b0;
		vid_f         = 1'b0;
		vid_h_sync    = 1'b0;
		vid_v_sync    = 1'b0;
		vid_locked    = 1'b0;
		forever
		begin
			pix = 16'h0000;
			repeat (3) tick(1'b0, 1'b1, 1'b0);
			if (run)
				repeat (2)
				begin
					repeat (2) tick(1'b1, 1'b0, 1'b0);
					for (int i = 0; i < 6; i++)
						tick(1'b0, 1'b0, i > 0 && i < 5);
				end
		end
	end
endmodule : cvi_video_source
`default_nettype wire

// *** tb/clocked_video_input_bridge_tb.sv ***
/*
 Self-checking bench of the video input bridge.
 Assumes the design sources and the source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module clocked_video_input_bridge_tb;
	logic        aclk = 1'b0, aresetn = 1'b0, run = 1'b0, stall = 1'b0, fmt = 1'b1;
	logic        vid_clk, vid_datavalid, vid_f, vid_h_sync, vid_v_sync, vid_locked;
	logic [15:0] vid_data, stream_pixel_out;
	logic        stream_beat_present, stream_frame_first, stream_frame_last, stream_sink_accept = 1'b0;
	logic        overflow, refclk_div, sof, sof_locked, status_update_int;
	logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awready, wready, bvalid, arready, rvalid, ref_q, sof_q, hold_q = 1'b0;
	logic [1:0]  bresp, rresp, r;
	logic [33:0] d;
	logic [35:0] held;
	logic [17:0] beats[$];
	int          bad_count = 0, samples_checked = 0, cyc = 0, last = 0, per = 0, sofs = 0;
	typedef struct packed {
		logic [5:0]  addr;
		logic [31:0] wd;
		logic [31:0] rd;
	} row_t;
	row_t rows [5] = '{
		'{6'h10, 32'h1, 32'h1},
		'{6'h14, 32'h1, 32'h1},
		'{6'h18, 32'h4, 32'h4},
		'{6'h0c, 32'hff, 32'h5},
		'{6'h00, 32'h7, 32'h7}
	};

	clocked_video_input_bridge #(.ADDR_W(6)) u_dut (
		.aclk, .aresetn, .vid_clk, .vid_data, .vid_datavalid, .vid_f, .vid_h_sync, .vid_v_sync,
		.plane_format_select(fmt), .vid_locked, .vid_std(3'h5), .stream_pixel_out,
		.stream_beat_present, .stream_frame_first, .stream_frame_last, .stream_sink_accept,
		.overflow, .refclk_div, .sof, .sof_locked, .status_update_int, .awaddr, .awvalid, .awready,
		.wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready(1'b1)
	);
	cvi_video_source u_src (.run, .vid_clk, .vid_data, .vid_datavalid, .vid_f, .vid_h_sync,
		.vid_v_sync, .vid_locked);

	always #5 aclk = ~aclk;

	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		r = bresp;
	endtask : wr

	task automatic rd(input logic [5:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = {rdata, rresp};
	endtask : rd

	// Sink accepts every other cycle unless stalled, so a beat waits at most one cycle
	always @(posedge aclk)
	begin
		cyc   <= cyc + 1;
		ref_q <= refclk_div;
		sof_q <= sof;
		if (refclk_div && !ref_q)
		begin
			last <= cyc;
			per  <= cyc - last;
		end
		if (sof && !sof_q)
			sofs <= sofs + 1;
		if (stream_beat_present && stream_sink_accept)
			beats.push_back({stream_frame_first, stream_frame_last, stream_pixel_out});
		if (hold_q)
			chk({17'h0, stream_beat_present, stream_frame_first, stream_frame_last, stream_pixel_out}, held);
		hold_q <= stream_beat_present && !stream_sink_accept;
		held   <= {17'h0, stream_beat_present, stream_frame_first, stream_frame_last, stream_pixel_out};
		stream_sink_accept <= !stall && !stream_sink_accept;
	end

	initial
	begin
		repeat (5000) @(posedge aclk);
		bad_count++;
		end_sim();
	end

	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		chk(36'({stream_beat_present, awready, bvalid, rvalid, overflow, sof_locked, status_update_int}), 36'h0);
		repeat (2) @(posedge aclk);
		rd(6'h00);
		chk(36'(d), 36'h0);
		$display("reset test done");
		foreach (rows[i])
		begin
			wr(rows[i].addr, rows[i].wd);
			chk(36'(r), 36'h0);
			rd(rows[i].addr);
			chk(36'(d), 36'({rows[i].rd, 2'h0}));
		end
		wr(6'h20, 32'h1);
		chk(36'(r), 36'h2);
		rd(6'h20);
		chk(36'(d), 36'h2);
		repeat (200) @(posedge aclk);
		chk(36'(per), 36'h20);
		$display("register test done");
		run <= 1'b1;
		while (beats.size() < 16)
			@(posedge aclk);
		chk(36'(sof_locked), 36'h1);
		run <= 1'b0;
		repeat (60) @(posedge aclk);
		chk(36'(beats.size()), 36'h10);
		chk(36'(sof_locked), 36'h0);
		chk(36'(sofs > 0), 36'h1);
		foreach (beats[i])
			chk(36'(beats[i]), {18'h0, i % 8 == 0, i % 8 == 7, 16'(i % 8 + 1)});
		$display("stream test done");
		// Low select with switching on: two samples per beat, plane 0 low
		fmt <= 1'b0;
		beats.delete();
		run <= 1'b1;
		while (beats.size() < 4)
			@(posedge aclk);
		run <= 1'b0;
		repeat (60) @(posedge aclk);
		chk(36'(beats.size()), 36'h4);
		foreach (beats[i])
			chk(36'(beats[i]), {18'h0, i == 0, i == 3, 8'(2 * i + 2), 8'(2 * i + 1)});
		$display("plane test done");
		stall <= 1'b1;
		run   <= 1'b1;
		repeat (400) @(posedge aclk);
		chk(36'({overflow, status_update_int}), 36'h3);
		run   <= 1'b0;
		stall <= 1'b0;
		repeat (60) @(posedge aclk);
		rd(6'h04);
		chk(36'(d[2]), 36'h1);
		wr(6'h00, 32'h1);
		// The pin follows the enable one edge after the response
		@(posedge aclk);
		chk(36'(status_update_int), 36'h0);
		wr(6'h04, 32'h1);
		wr(6'h08, 32'h1);
		wr(6'h00, 32'h5);
		repeat (4) @(posedge aclk);
		chk(36'({overflow, status_update_int}), 36'h0);
		$display("overflow test done");
		end_sim();
	end
endmodule : clocked_video_input_bridge_tb
`default_nettype wire
